// ---- inc/clto_pkg.sv ----
// package for the three-tap video output formatter: constants, layouts and types
package clto_pkg;

    // ========================================================================
    // sizes
    localparam int TAP_W      = 10;
    localparam int BYTE_W     = 8;
    localparam int LEN_W      = 16;
    localparam int CNT_W      = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int SYS_MHZ    = 25;

    // ========================================================================
    // start delay limits in ns, largest sensor, two-tap modes
    localparam int LV_CLR40_MIN_NS  = 3080;
    localparam int LV_CLR40_MAX_NS  = 3220;
    localparam int LV_CLR40E_MIN_NS = 3130;
    localparam int LV_CLR40E_MAX_NS = 3270;
    localparam int FV_RAW40_MIN_NS  = 3210;
    localparam int FV_RAW40_MAX_NS  = 3360;
    localparam int FV_ENH40_MIN_NS  = 3230;
    localparam int FV_ENH40_MAX_NS  = 3390;
    localparam int LV_CLR80_MIN_NS  = 2910;
    localparam int LV_CLR80_MAX_NS  = 3010;
    localparam int LV_CLR80E_MIN_NS = 2960;
    localparam int LV_CLR80E_MAX_NS = 3060;
    localparam int FV_RAW80_MIN_NS  = 3070;
    localparam int FV_RAW80_MAX_NS  = 3190;
    localparam int FV_ENH80_MIN_NS  = 3100;
    localparam int FV_ENH80_MAX_NS  = 3210;

    // least times round up to whole sys_clk cycles
    localparam logic [CNT_W-1:0] LV_CLR40_CYC  = CNT_W'((LV_CLR40_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] LV_CLR40E_CYC = CNT_W'((LV_CLR40E_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] FV_RAW40_CYC  = CNT_W'((FV_RAW40_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] FV_ENH40_CYC  = CNT_W'((FV_ENH40_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] LV_CLR80_CYC  = CNT_W'((LV_CLR80_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] LV_CLR80E_CYC = CNT_W'((LV_CLR80E_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] FV_RAW80_CYC  = CNT_W'((FV_RAW80_MIN_NS * SYS_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] FV_ENH80_CYC  = CNT_W'((FV_ENH80_MIN_NS * SYS_MHZ + 999) / 1000);

    // ========================================================================
    // register map, byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_LEN    = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_MEAS   = 8'h0C;

    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_TAP3_BIT  = 1;
    localparam int CTRL_BIT8_BIT  = 2;
    localparam int CTRL_ACQ_LSB   = 4;
    localparam int CTRL_EXP_LSB   = 6;
    localparam int CTRL_CLK80_BIT = 8;
    localparam int CTRL_W         = 9;

    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_LINE_BIT  = 1;
    localparam int STAT_EMPTY_BIT = 2;

    localparam logic [31:0] CTRL_RST = 32'h0000_0002;
    localparam logic [31:0] LEN_RST  = 32'h0000_0010;

    // ========================================================================
    // types
    typedef enum logic [1:0] {ACQ_COLOR, ACQ_RAW, ACQ_ENH_RAW} clto_acq_t;
    typedef enum logic [1:0] {EXP_PROG, EXP_EDGE, EXP_LEVEL} clto_exp_t;

    typedef struct packed {
        logic            enable;
        logic            three_tap;
        logic            eight_bit;
        clto_acq_t       acq;
        clto_exp_t       expo;
        logic            clk80;
    } clto_cfg_t;

    typedef struct packed {
        logic [TAP_W-1:0] tap_stream_two;
        logic [TAP_W-1:0] tap_stream_one;
        logic [TAP_W-1:0] tap_stream_zero;
    } clto_pix_t;

    // one transmitter's parallel input word
    typedef struct packed {
        logic [BYTE_W-1:0] port2;
        logic [BYTE_W-1:0] port1;
        logic [BYTE_W-1:0] port0;
        logic              spare;
        logic              fval;
        logic              dval;
        logic              lval;
    } clto_tx_t;

endpackage

// ---- hw/clto_fifo.sv ----
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module clto_fifo #(
    parameter int W     = 30,
    parameter int DEPTH = 8
) (
    input  wire logic         sys_clk,   // system clock
    input  wire logic         rst_n,     // async reset, active low
    input  wire logic         in_valid,  // writer offers a word
    input  wire logic [W-1:0] in_data,   // word offered
    output logic              in_ready,  // room for a word
    output logic              out_valid, // a word is held
    output logic      [W-1:0] out_data,  // oldest word
    input  wire logic         out_ready  // reader takes the word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST   = AW'(DEPTH - 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0]   cnt_q, cnt_d;
    logic          rdy_q;

    wire push = in_valid && rdy_q;
    wire pop  = out_ready && (cnt_q != '0);

    assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            wr_q  <= push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
            rd_q  <= pop ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != FULL_CNT);
        end
    end
endmodule
`default_nettype wire

// ---- hw/clto_top.sv ----
// three-tap video output formatter for the serial camera video link
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module clto_top
    import clto_pkg::*;
(
    input  wire logic        sys_clk,      // 25 MHz system clock
    input  wire logic        rst_n,        // async reset, active low
    input  wire logic        wb_cyc_i,     // wishbone cycle
    input  wire logic        wb_stb_i,     // wishbone strobe
    input  wire logic        wb_we_i,      // wishbone write
    input  wire logic [7:0]  wb_adr_i,     // wishbone byte address
    input  wire logic [31:0] wb_dat_i,     // wishbone write data
    input  wire logic [3:0]  wb_sel_i,     // wishbone byte lanes
    output logic      [31:0] wb_dat_o,     // wishbone read data
    output logic             wb_ack_o,     // wishbone acknowledge
    input  wire logic        link_clk,     // link pixel clock, asynchronous
    input  wire logic        readout_done, // end of sensor readout, one-cycle pulse
    input  wire logic        pix_valid,    // pixel triple offered
    input  wire clto_pix_t   pix_data,     // pixel triple, tap order
    output logic             pix_ready,    // fifo has room
    output clto_tx_t         tx_x,         // first transmitter parallel word
    output clto_tx_t         tx_y,         // second transmitter parallel word
    output logic             tx_clk_x,     // pixel clock to first transmitter
    output logic             tx_clk_y      // pixel clock to second transmitter
);

    // ========================================================================
    // state
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LINE} clto_state_t;

    clto_state_t         state_q;
    logic [31:0]         ctrl_q, len_reg_q;
    logic [31:0]         rdat_q;
    logic                ack_q;
    clto_cfg_t           act_q;
    logic [LEN_W-1:0]    len_q, cnt_q;
    logic [CNT_W-1:0]    dly_q, tgt_q, meas_run_q, meas_q;
    logic                first_q;
    logic                lclk_s1_q, lclk_s2_q, lclk_s3_q;
    clto_tx_t            tx_x_q, tx_y_q;
    logic                clk_x_q, clk_y_q;

    // ========================================================================
    // functions
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // start delay by acquisition mode, exposure mode and link rate
    function automatic logic [CNT_W-1:0] start_delay(input clto_cfg_t c);
        logic [CNT_W-1:0] d;
        d = LV_CLR40_CYC;
        if (c.acq == ACQ_RAW) begin
            d = c.clk80 ? FV_RAW80_CYC : FV_RAW40_CYC;
        end else if (c.acq == ACQ_ENH_RAW) begin
            d = c.clk80 ? FV_ENH80_CYC : FV_ENH40_CYC;
        end else if (c.clk80) begin
            d = (c.expo == EXP_EDGE) ? LV_CLR80E_CYC : LV_CLR80_CYC;
        end else begin
            d = (c.expo == EXP_EDGE) ? LV_CLR40E_CYC : LV_CLR40_CYC;
        end
        return d;
    endfunction

    // ========================================================================
    // wishbone slave
    wire       wb_req   = wb_cyc_i && wb_stb_i && !ack_q;
    wire       wb_wr    = wb_req && wb_we_i;
    wire       sel_ctrl = (wb_adr_i == REG_CTRL);
    wire       sel_len  = (wb_adr_i == REG_LEN);
    wire       sel_stat = (wb_adr_i == REG_STATUS);
    wire       sel_meas = (wb_adr_i == REG_MEAS);

    clto_cfg_t cfg_reg;
    assign cfg_reg.enable    = ctrl_q[CTRL_EN_BIT];
    assign cfg_reg.three_tap = ctrl_q[CTRL_TAP3_BIT];
    assign cfg_reg.eight_bit = ctrl_q[CTRL_BIT8_BIT];
    assign cfg_reg.acq       = clto_acq_t'(ctrl_q[CTRL_ACQ_LSB +: 2]);
    assign cfg_reg.expo      = clto_exp_t'(ctrl_q[CTRL_EXP_LSB +: 2]);
    assign cfg_reg.clk80     = ctrl_q[CTRL_CLK80_BIT];

    wire        fifo_v;
    wire [31:0] status_w;
    wire [31:0] rd_mux;
    assign status_w = {29'h0,
                       !fifo_v,
                       (state_q == ST_LINE),
                       (state_q != ST_IDLE)};

    // unmapped addresses read zero and ignore writes
    assign rd_mux = sel_ctrl ? ctrl_q
                  : sel_len  ? len_reg_q
                  : sel_stat ? status_w
                  : sel_meas ? {16'h0000, meas_q}
                  : 32'h0000_0000;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
            ctrl_q    <= CTRL_RST;
            len_reg_q <= LEN_RST;
        end else begin
            ack_q  <= wb_req;
            rdat_q <= wb_req ? rd_mux : 32'h0000_0000;
            if (wb_wr && sel_ctrl) begin
                ctrl_q <= wb_merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'(2**CTRL_W - 1);
            end
            if (wb_wr && sel_len) begin
                len_reg_q <= wb_merge(len_reg_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ========================================================================
    // link clock synchroniser and edge finder
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
        end else begin
            lclk_s1_q <= link_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
        end
    end

    wire lclk_rise = lclk_s2_q && !lclk_s3_q;

    // ========================================================================
    // pixel fifo
    clto_pix_t fifo_d;
    wire       pop;

    clto_fifo #(
        .W     ($bits(clto_pix_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (pix_valid),
        .in_data   (pix_data),
        .in_ready  (pix_ready),
        .out_valid (fifo_v),
        .out_data  (fifo_d),
        .out_ready (pop)
    );

    // ========================================================================
    // line sequencer
    wire start    = readout_done && cfg_reg.enable && (state_q == ST_IDLE);
    wire dly_done = (state_q == ST_WAIT) && (dly_q + 1'b1 >= tgt_q);
    wire line_end = (cnt_q == len_q);
    wire in_line  = (state_q == ST_LINE) && lclk_rise;
    wire send     = in_line && !line_end && fifo_v;
    wire fin      = in_line && line_end;
    assign pop    = send;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            act_q   <= '0;
            len_q   <= '0;
            tgt_q   <= '0;
            dly_q   <= '0;
            cnt_q   <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start) begin
                        act_q   <= cfg_reg;
                        len_q   <= len_reg_q[LEN_W-1:0];
                        tgt_q   <= start_delay(cfg_reg);
                        dly_q   <= '0;
                        cnt_q   <= '0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    dly_q <= dly_q + 1'b1;
                    if (dly_done) begin
                        state_q <= ST_LINE;
                    end
                end
                ST_LINE: begin
                    if (send) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                    if (fin) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================================================
    // start delay measurement
    wire launch_first = in_line && first_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            first_q    <= 1'b0;
            meas_run_q <= '0;
            meas_q     <= '0;
        end else begin
            if (start) begin
                first_q    <= 1'b1;
                meas_run_q <= '0;
            end else if (launch_first) begin
                first_q <= 1'b0;
                meas_q  <= meas_run_q + 1'b1;
            end else if (first_q && meas_run_q != '1) begin
                meas_run_q <= meas_run_q + 1'b1;
            end
        end
    end

    // ========================================================================
    // word formatting onto the two transmitters
    wire [TAP_W-1:0] t0 = fifo_d.tap_stream_zero;
    wire [TAP_W-1:0] t1 = fifo_d.tap_stream_one;
    wire [TAP_W-1:0] t2 = act_q.three_tap ? fifo_d.tap_stream_two : '0;
    wire             eb = act_q.eight_bit;
    wire             lv = in_line && !line_end;

    clto_tx_t x_w, y_w;
    // eight-bit keeps the top bits of each converter value
    assign x_w.port0 = !send ? '0 : eb ? t0[9:2] : t0[7:0];
    assign x_w.port1 = !send ? '0 : eb ? t1[9:2]
                     : {2'b00, t2[9:8], 2'b00, t0[9:8]};
    assign x_w.port2 = !send ? '0 : eb ? t2[9:2] : t2[7:0];
    assign x_w.spare = 1'b0;
    assign x_w.fval  = eb ? 1'b0 : lv;
    assign x_w.lval  = lv;
    assign x_w.dval  = send;

    // second transmitter: tap one in ten-bit mode, line and data valid always
    assign y_w.port0 = '0;
    assign y_w.port1 = (!send || eb) ? '0 : t1[7:0];
    assign y_w.port2 = (!send || eb) ? '0 : {6'h00, t1[9:8]};
    assign y_w.spare = 1'b0;
    assign y_w.fval  = 1'b0;
    assign y_w.lval  = lv;
    assign y_w.dval  = send;

    // words are registered at the transmitter parallel inputs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_x_q  <= '0;
            tx_y_q  <= '0;
        end else if (lclk_rise) begin
            tx_x_q  <= x_w;
            tx_y_q  <= y_w;
        end
    end

    // pixel clock forwarded to both transmitters
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_x_q <= 1'b0;
            clk_y_q <= 1'b0;
        end else begin
            clk_x_q <= lclk_s2_q;
            clk_y_q <= lclk_s2_q;
        end
    end

    assign tx_x     = tx_x_q;
    assign tx_y     = tx_y_q;
    assign tx_clk_x = clk_x_q;
    assign tx_clk_y = clk_y_q;

endmodule
`default_nettype wire

// ---- test/clto_top_properties.sv ----
// port assertions for the three-tap video output formatter
`timescale 1ns/1ps
`default_nettype none
module clto_top_checker
    import clto_pkg::*;
(
    input wire logic        sys_clk,  // system clock
    input wire logic        rst_n,    // async reset, active low
    input wire logic        wb_cyc_i, // bus cycle
    input wire logic        wb_stb_i, // bus strobe
    input wire logic [31:0] wb_dat_o, // read data
    input wire logic        wb_ack_o, // acknowledge
    input wire logic        link_clk, // link pixel clock
    input wire clto_tx_t    tx_x,     // first transmitter word
    input wire clto_tx_t    tx_y,     // second transmitter word
    input wire logic        tx_clk_x, // first pixel clock
    input wire logic        tx_clk_y  // second pixel clock
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    // ========================================================================
    // register bus
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");

    // ========================================================================
    // video link
    a_qual_paired: assert property (
        tx_x.lval == tx_y.lval && tx_x.dval == tx_y.dval)
        else $error("qualifiers differ between transmitters");
    a_clk_paired: assert property (tx_clk_x == tx_clk_y)
        else $error("pixel clocks differ");
    a_clk_follow: assert property (##3 tx_clk_x == $past(link_clk, 3))
        else $error("pixel clock not three cycles behind link clock");
    a_launch_edge: assert property (
        $changed(tx_x) || $changed(tx_y) |-> $rose(tx_clk_x))
        else $error("word changed away from a pixel clock rise");
    a_dval_in_line: assert property (tx_x.dval |-> tx_x.lval)
        else $error("data valid outside line valid");
    a_idle_zero: assert property (!tx_x.dval |->
        {tx_x.port2, tx_x.port1, tx_x.port0, tx_y.port2, tx_y.port1} == 40'h00_0000_0000)
        else $error("tap data without data valid");
    a_unused_zero: assert property (
        tx_y.port0 == 8'h00 && tx_y.port2[7:2] == 6'h00
        && !tx_y.fval && !tx_x.spare && !tx_y.spare)
        else $error("unused bit driven");
    a_fval_line: assert property (tx_x.fval |-> tx_x.lval)
        else $error("frame valid outside line");
endmodule

bind clto_top clto_top_checker u_clto_top_checker (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .link_clk (link_clk),
    .tx_x     (tx_x),
    .tx_y     (tx_y),
    .tx_clk_x (tx_clk_x),
    .tx_clk_y (tx_clk_y)
);
`default_nettype wire

// ---- test/clto_grabber.sv ----
// frame grabber model: rebuilds pixel triples from both transmitter words in ten-bit mode, from the first alone in eight-bit
`timescale 1ns/1ps
`default_nettype none
module clto_grabber
    import clto_pkg::*;
(
    input wire logic     sys_clk,  // samples the link
    input wire clto_tx_t tx_x,     // first transmitter word
    input wire clto_tx_t tx_y,     // second transmitter word
    input wire logic     tx_clk_x, // pixel clock
    input wire logic     eight_bit // receiver set for eight-bit taps
);
    clto_pix_t got[$];
    int        lines;
    int        fv_bad;
    logic      clk_q;
    logic      lval_q;

    // ========================================================================
    // one sample per pixel clock rise, taken a cycle later when settled
    always @(posedge sys_clk) begin
        clk_q <= tx_clk_x;
        if (tx_clk_x === 1'b1 && clk_q === 1'b0) begin
            lval_q <= tx_x.lval;
            if (lval_q === 1'b1 && tx_x.lval === 1'b0)
                lines++;
            if (tx_x.fval !== (eight_bit ? 1'b0 : tx_x.lval))
                fv_bad++;
            if (tx_x.lval === 1'b1 && tx_x.dval === 1'b1) begin
                if (eight_bit)
                    got.push_back({tx_x.port2, 2'b00, tx_x.port1, 2'b00,
                                   tx_x.port0, 2'b00});
                else
                    got.push_back({tx_x.port1[5:4], tx_x.port2, tx_y.port2[1:0], tx_y.port1,
                                   tx_x.port1[1:0], tx_x.port0});
            end
        end
    end
endmodule
`default_nettype wire

// ---- test/clto_top_tb.sv ----
// self-checking bench for the three-tap video output formatter
`timescale 1ns/1ps
`default_nettype none
module clto_top_tb
    import clto_pkg::*;
();
    localparam logic [31:0] NONE = 32'h0000_0000;
    logic        sys_clk = 1'b0;
    logic        rst_n, wb_cyc_i, wb_stb_i, wb_we_i, link_clk, readout_done, pix_valid;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    logic        wb_ack_o, pix_ready, tx_clk_x, tx_clk_y, grab_eight;
    clto_pix_t   pix_data, exp_q[$];
    clto_tx_t    tx_x, tx_y;
    int          mismatches, checked, cycles;

    clto_top u_clto_top (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk(link_clk),
        .readout_done(readout_done), .pix_valid(pix_valid), .pix_data(pix_data),
        .pix_ready(pix_ready), .tx_x(tx_x), .tx_y(tx_y), .tx_clk_x(tx_clk_x), .tx_clk_y(tx_clk_y));
    clto_grabber u_clto_grabber (.sys_clk(sys_clk), .tx_x(tx_x), .tx_y(tx_y),
        .tx_clk_x(tx_clk_x), .eight_bit(grab_eight));

    // ========================================================================
    // clocks and hang limit
    always #20 sys_clk = ~sys_clk;
    initial begin
        link_clk = 1'b0;
        #7;
        forever #160 link_clk = ~link_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    // ========================================================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] got);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] sel);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ========================================================================
    // scenarios
    task automatic t_regs();
        wb(1'b0, REG_CTRL, NONE, 4'hf);
        chk("ctrl reset", CTRL_RST, rd);
        wb(1'b0, REG_LEN, NONE, 4'hf);
        chk("len reset", LEN_RST, rd);
        wb(1'b1, REG_LEN, 32'hABCD_1234, 4'hf);
        wb(1'b1, REG_LEN, 32'h0000_00EF, 4'h1);
        wb(1'b0, REG_LEN, NONE, 4'hf);
        chk("len lanes", 32'h0000_12EF, rd);
        wb(1'b1, 8'h20, 32'hFFFF_FFFF, 4'hf);
        wb(1'b0, 8'h20, NONE, 4'hf);
        chk("unmapped", NONE, rd);
        // start event while disabled must be ignored
        readout_done <= 1'b1;
        @(posedge sys_clk);
        readout_done <= 1'b0;
        repeat (120) @(posedge sys_clk);
        wb(1'b0, REG_STATUS, NONE, 4'hf);
        chk("status disabled", 32'h0000_0004, rd);
        chk("lines disabled", NONE, 32'(u_clto_grabber.lines));
    endtask

    task automatic t_line(input int acq, input int ex, input bit c80, input bit three,
                          input bit eight, input int len);
        int         mn;
        int         mx;
        int         n0;
        logic [9:0] v[3];
        logic [9:0] mk;
        case ({c80, 2'(acq)})
            3'b000: {mn, mx} = (ex == 1) ? {LV_CLR40E_MIN_NS, LV_CLR40E_MAX_NS}
                                         : {LV_CLR40_MIN_NS, LV_CLR40_MAX_NS};
            3'b100: {mn, mx} = (ex == 1) ? {LV_CLR80E_MIN_NS, LV_CLR80E_MAX_NS}
                                         : {LV_CLR80_MIN_NS, LV_CLR80_MAX_NS};
            3'b001: {mn, mx} = {FV_RAW40_MIN_NS, FV_RAW40_MAX_NS};
            3'b101: {mn, mx} = {FV_RAW80_MIN_NS, FV_RAW80_MAX_NS};
            3'b010: {mn, mx} = {FV_ENH40_MIN_NS, FV_ENH40_MAX_NS};
            default: {mn, mx} = {FV_ENH80_MIN_NS, FV_ENH80_MAX_NS};
        endcase
        mk = eight ? 10'h3fc : 10'h3ff;
        wb(1'b1, REG_LEN, 32'(len), 4'hf);
        wb(1'b1, REG_CTRL, 32'({c80, 2'(ex), 2'(acq), 1'b0, eight, three, 1'b1}), 4'hf);
        grab_eight <= eight;
        u_clto_grabber.got.delete();
        exp_q.delete();
        pix_valid <= 1'b1;
        for (int k = 0; k < len; k++) begin
            for (int j = 0; j < 3; j++)
                v[j] = 10'((3 * k + j + 1) * 37 + acq * 101 + ex * 13);
            pix_data <= {v[2], v[1], v[0]};
            exp_q.push_back({three ? v[2] & mk : 10'h000, v[1] & mk, v[0] & mk});
            do @(posedge sys_clk); while (pix_ready !== 1'b1);
        end
        pix_valid <= 1'b0;
        if (len == 8) begin
            @(posedge sys_clk);
            chk("fifo full", NONE, 32'(pix_ready));
        end
        n0 = u_clto_grabber.lines;
        readout_done <= 1'b1;
        @(posedge sys_clk);
        readout_done <= 1'b0;
        // still counting the start delay: busy, not in line, fifo holding words
        wb(1'b0, REG_STATUS, NONE, 4'hf);
        chk("status waiting", 32'h0000_0001, rd);
        while (u_clto_grabber.lines == n0) @(posedge sys_clk);
        chk("pixel count", 32'(len), 32'(u_clto_grabber.got.size()));
        foreach (exp_q[i])
            chk("pixel triple", 32'(exp_q[i]),
                32'(u_clto_grabber.got[i]));
        chk("frame valid", NONE, 32'(u_clto_grabber.fv_bad));
        wb(1'b0, REG_MEAS, NONE, 4'hf);
        chk_rng("start delay", (mn * SYS_MHZ + 999) / 1000, (mx * SYS_MHZ + 999) / 1000 + 11,
                rd);
        wb(1'b0, REG_STATUS, NONE, 4'hf);
        chk("status after line", 32'h0000_0004, rd);
    endtask

    // ========================================================================
    // main sequence
    initial begin
        rst_n        = 1'b0;
        wb_cyc_i     = 1'b0;
        wb_stb_i     = 1'b0;
        wb_we_i      = 1'b0;
        wb_adr_i     = 8'h00;
        wb_dat_i     = NONE;
        wb_sel_i     = 4'h0;
        readout_done = 1'b0;
        pix_valid    = 1'b0;
        pix_data     = 30'h0000_0000;
        grab_eight   = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_regs();
        for (int i = 0; i < 18; i++)
            t_line(i / 6, (i / 2) % 3, i[0], i % 3 != 0, i % 3 != 0 && i[0],
                   i % 8 + 1);
        give_verdict();
    end
endmodule
`default_nettype wire
